// ### pkg/rmsbs_pkg.sv
// Constants and types for the reset, mode-strap and bus-status block.
// Assumes one clock domain and a synchronous active-low system reset.
package rmsbs_pkg;

    // Pin synchroniser lanes
    localparam int unsigned PIN_RES   = 0;
    localparam int unsigned PIN_UCS   = 1;
    localparam int unsigned PIN_LCS   = 2;
    localparam int unsigned PIN_QSMD  = 3;
    localparam int unsigned PIN_WAIT  = 4;
    localparam int unsigned PIN_COPRO = 5;
    localparam int unsigned PIN_W     = 6;
    // Sync stages start as: reset pin low, straps at pull-up level
    localparam logic [5:0]  PIN_RST_VAL = 6'h3e;

    // Active-low bus cycle status codes
    localparam logic [2:0] ST_INTA  = 3'h0;
    localparam logic [2:0] ST_IORD  = 3'h1;
    localparam logic [2:0] ST_IOWR  = 3'h2;
    localparam logic [2:0] ST_HALT  = 3'h3;
    localparam logic [2:0] ST_FETCH = 3'h4;
    localparam logic [2:0] ST_MEMRD = 3'h5;
    localparam logic [2:0] ST_MEMWR = 3'h6;
    localparam logic [2:0] ST_IDLE  = 3'h7;

    // Queue status codes, bit 1 on write strobe pin, bit 0 on latch pin
    localparam logic [1:0] QS_NONE   = 2'h0;
    localparam logic [1:0] QS_FIRST  = 2'h1;
    localparam logic [1:0] QS_MORE   = 2'h3;
    localparam logic [1:0] QS_FLUSH  = 2'h2;

    // Reset values of the latched modes
    localparam logic RST_PINS_FLOAT_TEST_MODE  = 1'b0;
    localparam logic RST_ENH   = 1'b0;
    localparam logic RST_QUEUE = 1'b0;

    typedef enum logic [3:0] {
        CYC_IDLE,
        CYC_INTA,
        CYC_IORD,
        CYC_IOWR,
        CYC_HALT,
        CYC_FETCH,
        CYC_MEMRD,
        CYC_MEMWR,
        CYC_REFRESH
    } rmsbs_cycle_t;

    typedef enum logic [1:0] {
        QOP_NONE,
        QOP_FIRST,
        QOP_MORE,
        QOP_FLUSH
    } rmsbs_qop_t;

endpackage : rmsbs_pkg

// ### pkg/rmsbs_pin_if.sv
// Carrier between the top and its pin synchroniser.
// Assumes raw pins from outside the clock domain, clean values inside.
interface rmsbs_pin_if #(
    parameter int unsigned W = 6
);
    logic [W-1:0] raw;
    logic [W-1:0] clean;

    modport sync_mp (input raw, output clean);
    modport user_mp (output raw, input clean);
endinterface : rmsbs_pin_if

// ### logic/rmsbs_pin_sync.sv
// Three-stage pin synchroniser with agreement filter per lane.
// Assumes pins asynchronous to clk_sys_i; reset values per lane given.
module rmsbs_pin_sync #(
    parameter int unsigned W       = 6,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input  wire logic     clk_sys_i,
    input  wire logic     resetn_i,
    // Pins
    rmsbs_pin_if.sync_mp  pins
);
    logic [W-1:0] s1_q, s2_q, s3_q, clean_q;
    logic [W-1:0] s1_d, s2_d, s3_d, clean_d;

    // Zero lanes leave the agreement filter with nothing to serve
    if (W < 1) begin : g_bad_width
        $error("rmsbs_pin_sync: W must be at least 1");
    end

    always_comb begin
        s1_d = pins.raw;
        s2_d = s1_q;
        s3_d = s2_q;
    end

    // Stage one is read by stage two only
    for (genvar i = 0; i < W; i++) begin : g_lane
        always_comb begin
            clean_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : clean_q[i];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            s1_q    <= RST_VAL;
            s2_q    <= RST_VAL;
            s3_q    <= RST_VAL;
            clean_q <= RST_VAL;
        end else begin
            s1_q    <= s1_d;
            s2_q    <= s2_d;
            s3_q    <= s3_d;
            clean_q <= clean_d;
        end
    end

    assign pins.clean = clean_q;

endmodule : rmsbs_pin_sync

// ### logic/rmsbs_top.sv
// Reset handling, reset-time mode straps and bus cycle status outputs.
// Assumes core signals on clk_sys_i; straps and reset pin are asynchronous.
//
// Overview of operation
// - External reset low holds core dormant
// - Reset output high while in reset
// - Refresh indicator low during refresh cycles in enhanced mode only
// - Three active-low status lines encode cycle type
// - Wait instruction stalls while resume pin high
// - Strap pull-ups enabled while reset applied
// - Both selects low at reset: pins float
// - Selects sampled at reset rising edge
// - Float mode left only via reset, straps high
// - Wait pin low then high: enhanced mode
// - Enhanced mode enables refresh, power-save, coprocessor
// - Detected coprocessor forces enhanced mode
// - Enhanced registers blocked outside enhanced mode
// - Queue status works in compatible mode
// - Mode pin low: queue status on pins
// - Queue codes: none, first, more, flush
module rmsbs_top
    import rmsbs_pkg::*;
(
    // Clock and reset
    input  wire logic                  clk_sys_i,
    input  wire logic                  resetn_i,
    // Reset and strap pins
    input  wire logic                  ext_reset_n_i,
    input  wire logic                  upper_select_n_i,
    input  wire logic                  lower_select_n_i,
    input  wire logic                  read_queue_mode_n_i,
    input  wire logic                  wait_resume_i,
    input  wire logic                  copro_detect_i,
    output logic                       reset_o,
    output logic                       pullup_en_o,
    // Core side
    output logic                       core_dormant_o,
    input  wire logic                  wait_active_i,
    output logic                       core_stall_o,
    input  wire rmsbs_pkg::rmsbs_cycle_t cycle_kind_i,
    input  wire rmsbs_pkg::rmsbs_qop_t queue_op_i,
    input  wire logic                  addr_latch_i,
    input  wire logic                  write_strobe_n_i,
    input  wire logic                  enh_reg_req_i,
    output logic                       enh_reg_grant_o,
    // Bus status pins
    output logic                       cycle_type_bit0_low_o,
    output logic                       cycle_type_bit1_low_o,
    output logic                       cycle_type_bit2_low_o,
    output logic                       refresh_n_o,
    output logic                       address_latch_queue_bit0_o,
    output logic                       write_strobe_queue_bit1_o,
    output logic                       pins_oe_n_o,
    // Mode status
    output logic                       pins_float_test_mode_o,
    output logic                       enhanced_mode_o,
    output logic                       queue_mode_o,
    output logic                       refresh_en_o,
    output logic                       power_save_en_o,
    output logic                       copro_en_o
);
    import rmsbs_pkg::*;

    rmsbs_pin_if #(.W(PIN_W)) pin_bus ();

    assign pin_bus.raw = {copro_detect_i, wait_resume_i, read_queue_mode_n_i,
                          lower_select_n_i, upper_select_n_i, ext_reset_n_i};

    rmsbs_pin_sync #(
        .W       (PIN_W),
        .RST_VAL (PIN_RST_VAL)
    ) u_sync (
        .clk_sys_i (clk_sys_i),
        .resetn_i  (resetn_i),
        .pins      (pin_bus)
    );

    logic res_n_c, ucs_n_c, lcs_n_c, qsmd_n_c, wait_c, copro_c;
    assign res_n_c  = pin_bus.clean[PIN_RES];
    assign ucs_n_c  = pin_bus.clean[PIN_UCS];
    assign lcs_n_c  = pin_bus.clean[PIN_LCS];
    assign qsmd_n_c = pin_bus.clean[PIN_QSMD];
    assign wait_c   = pin_bus.clean[PIN_WAIT];
    assign copro_c  = pin_bus.clean[PIN_COPRO];

    function automatic logic [2:0] cycle_code(input rmsbs_cycle_t k,
                                              input logic enh);
        case (k)
            CYC_INTA:    cycle_code = ST_INTA;
            CYC_IORD:    cycle_code = ST_IORD;
            CYC_IOWR:    cycle_code = ST_IOWR;
            CYC_HALT:    cycle_code = ST_HALT;
            CYC_FETCH:   cycle_code = ST_FETCH;
            CYC_MEMRD:   cycle_code = ST_MEMRD;
            CYC_MEMWR:   cycle_code = ST_MEMWR;
            // Refresh shows as a memory read, only when enhanced
            CYC_REFRESH: cycle_code = enh ? ST_MEMRD : ST_IDLE;
            default:     cycle_code = ST_IDLE;
        endcase
    endfunction : cycle_code

    function automatic logic [1:0] queue_code(input rmsbs_qop_t op);
        case (op)
            QOP_FIRST: queue_code = QS_FIRST;
            QOP_MORE:  queue_code = QS_MORE;
            QOP_FLUSH: queue_code = QS_FLUSH;
            default:   queue_code = QS_NONE;
        endcase
    endfunction : queue_code

    // Reset tracking and mode straps
    logic res_prev_q, res_prev_d;
    logic wait_low_q, wait_low_d;
    logic pins_float_test_mode_q, pins_float_test_mode_d, enh_q, enh_d, queue_q, queue_d;
    logic in_reset, release_edge;

    assign in_reset     = !res_n_c;
    assign release_edge = res_n_c && !res_prev_q;

    always_comb begin
        res_prev_d = res_n_c;
        wait_low_d = wait_low_q;
        pins_float_test_mode_d     = pins_float_test_mode_q;
        enh_d      = enh_q;
        queue_d    = queue_q;
        if (in_reset && !wait_c) begin
            wait_low_d = 1'b1;
        end
        if (release_edge) begin
            pins_float_test_mode_d     = !ucs_n_c && !lcs_n_c;
            enh_d      = (wait_low_q && wait_c) || copro_c;
            queue_d    = !qsmd_n_c;
            wait_low_d = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            res_prev_q <= 1'b0;
            wait_low_q <= 1'b0;
            pins_float_test_mode_q     <= RST_PINS_FLOAT_TEST_MODE;
            enh_q      <= RST_ENH;
            queue_q    <= RST_QUEUE;
        end else begin
            res_prev_q <= res_prev_d;
            wait_low_q <= wait_low_d;
            pins_float_test_mode_q     <= pins_float_test_mode_d;
            enh_q      <= enh_d;
            queue_q    <= queue_d;
        end
    end

    // Registered pin and core outputs
    typedef struct packed {
        logic       rst;
        logic       pull;
        logic       dormant;
        logic       stall;
        logic       grant;
        logic [2:0] st_n;
        logic       rfsh_n;
        logic       qb0;
        logic       qb1;
        logic       oe_n;
        logic       pins_float_test_mode;
        logic       enh;
        logic       queue;
    } rmsbs_out_t;

    localparam rmsbs_out_t OUT_RST = '{rst: 1'b1, pull: 1'b1, dormant: 1'b1,
        stall: 1'b0, grant: 1'b0, st_n: ST_IDLE, rfsh_n: 1'b1, qb0: 1'b0,
        qb1: 1'b1, oe_n: 1'b0, pins_float_test_mode: RST_PINS_FLOAT_TEST_MODE, enh: RST_ENH,
        queue: RST_QUEUE};

    rmsbs_out_t out_q, out_d;
    logic [1:0] qs;

    always_comb begin
        qs            = queue_code(queue_op_i);
        out_d         = OUT_RST;
        out_d.pins_float_test_mode    = pins_float_test_mode_q;
        out_d.enh     = enh_q;
        out_d.queue   = queue_q;
        out_d.oe_n    = pins_float_test_mode_q;
        if (!in_reset) begin
            out_d.rst     = 1'b0;
            out_d.pull    = 1'b0;
            out_d.dormant = 1'b0;
            out_d.stall   = wait_active_i && wait_c;
            out_d.grant   = enh_reg_req_i && enh_q;
            out_d.st_n    = cycle_code(cycle_kind_i, enh_q);
            out_d.rfsh_n  = !(enh_q &&
                              cycle_kind_i == CYC_REFRESH);
            // Queue mode does not depend on enhanced mode
            out_d.qb0     = queue_q ? qs[0] : addr_latch_i;
            out_d.qb1     = queue_q ? qs[1] : write_strobe_n_i;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            out_q <= OUT_RST;
        end else begin
            out_q <= out_d;
        end
    end

    assign reset_o                    = out_q.rst;
    assign pullup_en_o                = out_q.pull;
    assign core_dormant_o             = out_q.dormant;
    assign core_stall_o               = out_q.stall;
    assign enh_reg_grant_o            = out_q.grant;
    assign cycle_type_bit0_low_o      = out_q.st_n[0];
    assign cycle_type_bit1_low_o      = out_q.st_n[1];
    assign cycle_type_bit2_low_o      = out_q.st_n[2];
    assign refresh_n_o                = out_q.rfsh_n;
    assign address_latch_queue_bit0_o = out_q.qb0;
    assign write_strobe_queue_bit1_o  = out_q.qb1;
    assign pins_oe_n_o                = out_q.oe_n;
    assign pins_float_test_mode_o     = out_q.pins_float_test_mode;
    assign enhanced_mode_o            = out_q.enh;
    assign queue_mode_o               = out_q.queue;
    assign refresh_en_o               = out_q.enh;
    assign power_save_en_o            = out_q.enh;
    assign copro_en_o                 = out_q.enh;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);

    AST_DORMANT: assert property (in_reset
        |=> core_dormant_o && reset_o)
        else $error("core not dormant during reset");
    AST_RESET_OUT: assert property (!in_reset |=> !reset_o)
        else $error("reset output high outside reset");
    AST_REFRESH: assert property (!in_reset && enh_q &&
        cycle_kind_i == CYC_REFRESH |=> !refresh_n_o)
        else $error("refresh indicator not low in refresh cycle");
    AST_STATUS_IO: assert property (!in_reset
        && cycle_kind_i == CYC_IOWR
        |=> {cycle_type_bit2_low_o, cycle_type_bit1_low_o,
             cycle_type_bit0_low_o} == ST_IOWR)
        else $error("wrong status code for io write");
    AST_STALL: assert property (!in_reset && wait_active_i && !wait_c
        |=> !core_stall_o)
        else $error("stall held with resume pin low");
    AST_PULLUP: assert property ($fell(res_n_c) |=> pullup_en_o)
        else $error("pull-ups off during reset");
    AST_PINS_FLOAT_TEST_MODE: assert property (release_edge && !ucs_n_c && !lcs_n_c
        |=> pins_float_test_mode_q ##1 pins_oe_n_o)
        else $error("float mode not entered");
    AST_PINS_FLOAT_TEST_MODE_HOLD: assert property (pins_float_test_mode_q && !release_edge
        |=> pins_float_test_mode_q)
        else $error("float mode left without reset");
    AST_ENH: assert property (release_edge && copro_c
        |=> enh_q ##1 enhanced_mode_o)
        else $error("coprocessor did not force enhanced mode");
    AST_BLOCK: assert property (!enh_q |=> !enh_reg_grant_o)
        else $error("enhanced register granted outside enhanced mode");
    AST_QUEUE: assert property (!in_reset && queue_q &&
        queue_op_i == QOP_FLUSH |=> write_strobe_queue_bit1_o &&
        !address_latch_queue_bit0_o)
        else $error("wrong flush queue code");
    AST_LATCH: assert property (!release_edge
        |=> $stable(queue_q) && $stable(enh_q))
        else $error("mode changed outside reset release");

    COV_PINS_FLOAT_TEST_MODE:  cover property (release_edge && !ucs_n_c && !lcs_n_c);
    COV_ENH:   cover property (wait_low_q && release_edge && wait_c);
    COV_QUEUE: cover property (queue_q && queue_op_i == QOP_MORE);
    COV_RFSH:  cover property (!refresh_n_o);

endmodule : rmsbs_top

// ### tb/rmsbs_sys_model.sv
// Far-side model: external reset circuit and the strap pins.
// Assumes the bench picks which straps are driven; the others float.
module rmsbs_sys_model (
    // Clock and control
    input  wire logic       clk_sys_i,
    input  wire logic       pullup_en_i,
    input  wire logic       rst_req_i,
    input  wire logic [4:0] drv_en_i,
    input  wire logic [4:0] drv_val_i,
    // Pins
    output logic            ext_reset_n_o,
    output logic [4:0]      pins_o
);
    timeunit 1ns;
    timeprecision 100ps;

    logic flip_q = 1'b0;

    always @(posedge clk_sys_i) begin
        flip_q <= ~flip_q;
    end

    assign ext_reset_n_o = rst_req_i;

    // Copro line has no pull-up; a floating line never holds its value
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            if (drv_en_i[i]) begin
                pins_o[i] = drv_val_i[i];
            end else if (pullup_en_i && i < 4) begin
                pins_o[i] = 1'b1;
            end else begin
                pins_o[i] = flip_q;
            end
        end
    end
endmodule : rmsbs_sys_model

// ### tb/rmsbs_top_tb.sv
// Bench for the reset, mode-strap and bus-status block.
// Assumes the far-side model resolves strap pins and the reset pin.
`define CHK(nm, ex, got) begin samples_checked++; \
    if ((got) !== (ex)) begin fail_count++; \
    $display("BAD %s exp %0h got %0h", nm, ex, got); end end
module rmsbs_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import rmsbs_pkg::*;

    logic clk_sys_i = 1'b0, resetn_i = 1'b0, rst_req = 1'b0;
    logic ext_reset_n_i, upper_select_n_i, lower_select_n_i;
    logic read_queue_mode_n_i, wait_resume_i, copro_detect_i;
    logic reset_o, pullup_en_o, core_dormant_o, core_stall_o;
    logic wait_active_i = 1'b0, addr_latch_i = 1'b0;
    logic write_strobe_n_i = 1'b1, enh_reg_req_i = 1'b0;
    rmsbs_cycle_t cycle_kind_i = CYC_IDLE;
    rmsbs_qop_t queue_op_i = QOP_NONE;
    logic enh_reg_grant_o, refresh_n_o, pins_oe_n_o;
    logic cycle_type_bit0_low_o, cycle_type_bit1_low_o;
    logic cycle_type_bit2_low_o, address_latch_queue_bit0_o;
    logic write_strobe_queue_bit1_o, pins_float_test_mode_o;
    logic enhanced_mode_o, queue_mode_o, refresh_en_o;
    logic power_save_en_o, copro_en_o, ef, ee, eq;
    logic [4:0] drv_en = 5'h1f, drv_val = 5'h0f, pins;
    int fail_count = 0, samples_checked = 0, cyc = 0;
    // Per case: driven mask, strap values, wait low-then-high
    localparam logic [10:0] CASES [8] = '{11'h400, 11'h4c0, 11'h440,
        11'h420, 11'h4c0, 11'h500, 11'h401, 11'h520};
    localparam logic [2:0] CODES [9] = '{ST_IDLE, ST_INTA, ST_IORD,
        ST_IOWR, ST_HALT, ST_FETCH, ST_MEMRD, ST_MEMWR, ST_MEMRD};
    localparam logic [1:0] QCODES [4] = '{QS_NONE, QS_FIRST, QS_MORE,
        QS_FLUSH};

    assign {copro_detect_i, wait_resume_i, read_queue_mode_n_i,
            lower_select_n_i, upper_select_n_i} = pins;

    rmsbs_sys_model i_rmsbs_sys_model (.clk_sys_i, .pullup_en_i(pullup_en_o),
        .rst_req_i(rst_req), .drv_en_i(drv_en), .drv_val_i(drv_val),
        .ext_reset_n_o(ext_reset_n_i), .pins_o(pins));

    rmsbs_top i_rmsbs_top (.clk_sys_i, .resetn_i, .ext_reset_n_i,
        .upper_select_n_i, .lower_select_n_i, .read_queue_mode_n_i,
        .wait_resume_i, .copro_detect_i, .reset_o, .pullup_en_o,
        .core_dormant_o, .wait_active_i, .core_stall_o, .cycle_kind_i,
        .queue_op_i, .addr_latch_i, .write_strobe_n_i, .enh_reg_req_i,
        .enh_reg_grant_o, .cycle_type_bit0_low_o, .cycle_type_bit1_low_o,
        .cycle_type_bit2_low_o, .refresh_n_o, .address_latch_queue_bit0_o,
        .write_strobe_queue_bit1_o, .pins_oe_n_o, .pins_float_test_mode_o,
        .enhanced_mode_o, .queue_mode_o, .refresh_en_o, .power_save_en_o,
        .copro_en_o);

    always #4 clk_sys_i = ~clk_sys_i;

    // A full run needs about 500 cycles
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            report_and_stop();
        end
    end

    task report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop

    task step;
        @(posedge clk_sys_i);
        #1;
    endtask : step

    task automatic chk_in_reset;
        `CHK("reset_o", 1'b1, reset_o)
        `CHK("dormant", 1'b1, core_dormant_o)
        `CHK("status", 3'h7, {cycle_type_bit2_low_o, cycle_type_bit1_low_o,
            cycle_type_bit0_low_o})
    endtask : chk_in_reset

    task automatic chk_modes;
        `CHK("float", ef, pins_float_test_mode_o)
        `CHK("oe_n", ef, pins_oe_n_o)
        `CHK("enh", ee, enhanced_mode_o)
        `CHK("feat", {3{ee}}, {refresh_en_o, power_save_en_o,
            copro_en_o})
        `CHK("queue", eq, queue_mode_o)
    endtask : chk_modes

    task automatic boot(input logic [10:0] c);
        int n;
        rst_req = 1'b0;
        cycle_kind_i = CYC_MEMWR;
        for (n = 0; n < 20 && pullup_en_o !== 1'b1; n++) step();
        step();
        chk_in_reset();
        `CHK("pullup", 1'b1, pullup_en_o)
        drv_en = c[10:6] | (c[0] ? 5'h08 : 5'h00);
        drv_val = c[5:1];
        repeat (8) step();
        drv_val[3] = 1'b1;
        repeat (8) step();
        rst_req = 1'b1;
        for (n = 0; n < 30 && reset_o !== 1'b0; n++) step();
        repeat (4) step();
        drv_en = 5'h1f;
        drv_val = 5'h0f;
        ef = c[6] & c[7] & ~c[1] & ~c[2];
        eq = c[8] & ~c[3];
        ee = c[0] | (c[10] & c[5]);
        chk_modes();
        `CHK("run", 3'h0, {reset_o, pullup_en_o, core_dormant_o})
    endtask : boot

    task automatic bus_checks;
        int n;
        logic [2:0] ex;
        for (int i = 0; i < 9; i++) begin
            cycle_kind_i = rmsbs_cycle_t'(i);
            step();
            ex = (i == 8 && !ee) ? ST_IDLE : CODES[i];
            `CHK("status", ex, {cycle_type_bit2_low_o, cycle_type_bit1_low_o,
                cycle_type_bit0_low_o})
            `CHK("refresh_n", !(i == 8 && ee), refresh_n_o)
        end
        addr_latch_i = 1'b1;
        write_strobe_n_i = 1'b0;
        for (int i = 0; i < 4; i++) begin
            queue_op_i = rmsbs_qop_t'(i);
            step();
            `CHK("qbits", eq ? QCODES[i] : 2'h1, {write_strobe_queue_bit1_o,
                address_latch_queue_bit0_o})
        end
        enh_reg_req_i = 1'b1;
        step();
        `CHK("grant", ee, enh_reg_grant_o)
        enh_reg_req_i = 1'b0;
        wait_active_i = 1'b1;
        for (n = 0; n < 12 && core_stall_o !== 1'b1; n++) step();
        `CHK("stall", 1'b1, core_stall_o)
        drv_val[3] = 1'b0;
        for (n = 0; n < 12 && core_stall_o !== 1'b0; n++) step();
        `CHK("resume", 1'b0, core_stall_o)
        drv_val = 5'h10;
        repeat (10) step();
        chk_modes();
        drv_val = 5'h0f;
        wait_active_i = 1'b0;
        queue_op_i = QOP_NONE;
    endtask : bus_checks

    initial begin
        repeat (16) step();
        chk_in_reset();
        resetn_i = 1'b1;
        for (int i = 0; i < 8; i++) begin
            boot(CASES[i]);
            bus_checks();
            $display("test %0d done", i);
        end
        report_and_stop();
    end
endmodule : rmsbs_top_tb
